/* File: common/sia_if.sv */
/*
   the shared serial interrupt wire between one host and one slave.
   assumes a pull-up: the line reads low when any end drives low.
*/
`timescale 1ns/10ps
interface sia_if;

   // -------------------------------------------------------------
   // drivers and resolved level
   // -------------------------------------------------------------
   logic host_o;
   logic host_oe;
   logic slave_o;
   logic slave_oe;
   logic line;

   // wired-or low, pulled high when nobody drives low
   assign line = ~((host_oe & ~host_o) | (slave_oe & ~slave_o));

   modport host (output host_o, output host_oe, input line);
   modport slave (output slave_o, output slave_oe, input line);

endinterface

/* File: common/sia_pkg.sv */
/*
   shared constants and types for the serialized interrupt link:
   frame counts, pulse widths, phases and the state sets of both ends.
   assumes a single clock shared by both ends and the line.
*/
package sia_pkg;

   // -------------------------------------------------------------
   // frame layout
   // -------------------------------------------------------------
   // irq0..irq15 plus the io channel check frame
   localparam int NUM_FRAMES = 17;
   localparam logic [4:0] FIRST_FRAME = 5'h01;
   localparam logic [4:0] LAST_FRAME = 5'h11;
   localparam logic [4:0] START_FRAME = 5'h00;

   // -------------------------------------------------------------
   // pulse widths in clocks
   // -------------------------------------------------------------
   localparam logic [3:0] START_MIN = 4'h4;
   localparam logic [3:0] START_MAX = 4'h8;
   localparam logic [3:0] STOP_QUIET = 4'h2;
   localparam logic [3:0] STOP_CONT = 4'h3;
   localparam logic [3:0] WIDTH_SAT = 4'hF;
   localparam logic [3:0] WIDTH_ONE = 4'h1;
   localparam logic [3:0] WIDTH_TWO = 4'h2;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [NUM_FRAMES-1:0] LEVELS_RESET = 17'h1FFFF;

   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      SIA_PH_SAMPLE,
      SIA_PH_RECOVER,
      SIA_PH_TURN
   } sia_phase_t;

   typedef enum logic [2:0] {
      SIA_S_IDLE,
      SIA_S_START,
      SIA_S_FRAMES,
      SIA_S_STOP_WAIT,
      SIA_S_STOP_LOW
   } sia_slave_state_t;

   typedef enum logic [2:0] {
      SIA_H_IDLE,
      SIA_H_START,
      SIA_H_FRAMES,
      SIA_H_STOP,
      SIA_H_STOP_REC,
      SIA_H_STOP_TURN
   } sia_host_state_t;

endpackage

/* File: hw/sia_host.sv */
/*
   host end of the serialized interrupt link: runs start, 17 frames and
   stop, collects the levels and picks the next cycle's mode.
   assumes one slave end on the shared line and a common clock.
*/
`timescale 1ns/10ps
module sia_host (
   // clock, enable and reset
   input wire logic CLOCK,
   input wire logic CE,
   input wire logic SRST,
   // control
   input wire logic RUN,
   input wire logic POLL,
   input wire logic QUIET_NEXT,
   input wire logic [3:0] START_LEN,
   // collected levels
   output logic [sia_pkg::NUM_FRAMES-1:0] IRQ_STATE,
   output logic UPDATE,
   output logic QUIET_MODE,
   // link
   sia_if.host LINK
);

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   sia_pkg::sia_host_state_t st_q, st_d;
   sia_pkg::sia_phase_t ph_q, ph_d;
   logic [4:0] fr_q, fr_d;
   logic [3:0] cnt_q, cnt_d;
   logic [3:0] len;
   logic [3:0] stop_len;
   logic qsel_q;
   logic quiet_q;
   logic oe_q;
   logic o_q;
   logic upd_q;
   logic [sia_pkg::NUM_FRAMES-1:0] irq_q;

   // -------------------------------------------------------------
   // widths
   // -------------------------------------------------------------
   always_comb begin
      if (START_LEN < sia_pkg::START_MIN) begin
         len = sia_pkg::START_MIN;
      end else if (START_LEN > sia_pkg::START_MAX) begin
         len = sia_pkg::START_MAX;
      end else begin
         len = START_LEN;
      end
   end
   assign stop_len = qsel_q ? sia_pkg::STOP_QUIET : sia_pkg::STOP_CONT;

   // -------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      fr_d = fr_q;
      cnt_d = cnt_q;
      case (st_q)
         sia_pkg::SIA_H_IDLE: begin
            if (RUN && POLL) begin
               st_d = sia_pkg::SIA_H_START;
               cnt_d = sia_pkg::WIDTH_ONE;
            end else if (RUN && quiet_q && !LINK.line) begin
               // slave already gave the first low clock
               st_d = sia_pkg::SIA_H_START;
               cnt_d = sia_pkg::WIDTH_TWO;
            end
         end
         sia_pkg::SIA_H_START: begin
            if (cnt_q >= len) begin
               st_d = sia_pkg::SIA_H_FRAMES;
               ph_d = sia_pkg::SIA_PH_RECOVER;
               fr_d = sia_pkg::START_FRAME;
            end else begin
               cnt_d = cnt_q + sia_pkg::WIDTH_ONE;
            end
         end
         sia_pkg::SIA_H_FRAMES: begin
            case (ph_q)
               sia_pkg::SIA_PH_SAMPLE: ph_d = sia_pkg::SIA_PH_RECOVER;
               sia_pkg::SIA_PH_RECOVER: ph_d = sia_pkg::SIA_PH_TURN;
               default: begin
                  if (fr_q == sia_pkg::LAST_FRAME) begin
                     st_d = sia_pkg::SIA_H_STOP;
                     cnt_d = sia_pkg::WIDTH_ONE;
                  end else begin
                     fr_d = fr_q + sia_pkg::FIRST_FRAME;
                     ph_d = sia_pkg::SIA_PH_SAMPLE;
                  end
               end
            endcase
         end
         sia_pkg::SIA_H_STOP: begin
            if (cnt_q >= stop_len) begin
               st_d = sia_pkg::SIA_H_STOP_REC;
            end else begin
               cnt_d = cnt_q + sia_pkg::WIDTH_ONE;
            end
         end
         sia_pkg::SIA_H_STOP_REC: st_d = sia_pkg::SIA_H_STOP_TURN;
         default: st_d = sia_pkg::SIA_H_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         st_q <= sia_pkg::SIA_H_IDLE;
         ph_q <= sia_pkg::SIA_PH_TURN;
         fr_q <= sia_pkg::START_FRAME;
         cnt_q <= '0;
      end else if (CE) begin
         st_q <= st_d;
         ph_q <= ph_d;
         fr_q <= fr_d;
         cnt_q <= cnt_d;
      end
   end

   // -------------------------------------------------------------
   // line drive, follows the next state so outputs stay registered
   // -------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         oe_q <= 1'b0;
         o_q <= 1'b1;
      end else if (CE) begin
         oe_q <= (st_d == sia_pkg::SIA_H_START) || (st_d == sia_pkg::SIA_H_STOP) ||
                 (st_d == sia_pkg::SIA_H_STOP_REC) ||
                 (st_d == sia_pkg::SIA_H_FRAMES && fr_d == sia_pkg::START_FRAME &&
                  ph_d == sia_pkg::SIA_PH_RECOVER);
         o_q <= !((st_d == sia_pkg::SIA_H_START) || (st_d == sia_pkg::SIA_H_STOP));
      end
   end

   // -------------------------------------------------------------
   // collection and mode
   // -------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         irq_q <= sia_pkg::LEVELS_RESET;
         upd_q <= 1'b0;
         qsel_q <= 1'b0;
         quiet_q <= 1'b0;
      end else if (CE) begin
         upd_q <= 1'b0;
         if (st_q == sia_pkg::SIA_H_FRAMES && ph_q == sia_pkg::SIA_PH_SAMPLE) begin
            irq_q[fr_q - sia_pkg::FIRST_FRAME] <= LINK.line;
         end
         if (st_q == sia_pkg::SIA_H_FRAMES && st_d == sia_pkg::SIA_H_STOP) begin
            qsel_q <= QUIET_NEXT;
            upd_q <= 1'b1;
         end
         if (st_q == sia_pkg::SIA_H_STOP_TURN) begin
            quiet_q <= qsel_q;
         end
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign IRQ_STATE = irq_q;
   assign UPDATE = upd_q;
   assign QUIET_MODE = quiet_q;
   assign LINK.host_oe = oe_q;
   assign LINK.host_o = o_q;

endmodule

/* File: hw/sia_slave.sv */
/*
   slave end of the serialized interrupt link: reports 17 source levels
   in their frames, starts cycles in quiet mode, decodes the stop width.
   assumes sources and line synchronous to CLOCK; host on the far end.
*/
// Contract
// - link active only while enable bit set
// - report rising and falling source transitions
// - cycle: one start, frames, one stop
// - all activity timed by the link clock
// - quiet: anyone starts; continuous: host only
// - continuous mode after reset
// - mode changes only from measured stop width; clearing SERIRQ_ENABLE also forces continuous here
// - start pulse low four to eight clocks
// - stop two clocks quiet, three continuous
// - tolerate idle clocks before stop pulse
// - next start directly or after gap
// - frames have sample, recovery, turn-around phases
// - frames irq0..irq15 then io check
// - sample at three times frame minus one
// - low if source low, high recovery, float
// - slave start: one low clock, then float
// - start no earlier than second clock after stop
`timescale 1ns/10ps
module sia_slave (
   // clock, enable and reset
   input wire logic CLOCK,
   input wire logic CE,
   input wire logic SRST,
   // configuration
   input wire logic SERIRQ_ENABLE,
   // source levels, bit 16 is the io channel check frame
   input wire logic [sia_pkg::NUM_FRAMES-1:0] IRQ_LEVELS,
   // status
   output logic QUIET_MODE,
   // link
   sia_if.slave LINK
);

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   sia_pkg::sia_slave_state_t state_q;
   sia_pkg::sia_phase_t ph_q;
   logic [4:0] fr_q;
   logic [3:0] width_q;
   logic quiet_q;
   logic oe_q;
   logic o_q;
   logic drove_q;
   logic [sia_pkg::NUM_FRAMES-1:0] src_q;
   logic [sia_pkg::NUM_FRAMES-1:0] rep_q;
   logic low;
   logic pending;
   logic next_sample;
   logic stop_ok;

   // -------------------------------------------------------------
   // decode
   // -------------------------------------------------------------
   assign low = ~LINK.line;
   // any level that differs from the one last sent needs a cycle
   assign pending = |(src_q ^ rep_q);
   // turn-around ending into the sample phase of the next frame
   assign next_sample = (state_q == sia_pkg::SIA_S_FRAMES) &&
                        (ph_q == sia_pkg::SIA_PH_TURN) &&
                        (fr_q != sia_pkg::LAST_FRAME);
   assign stop_ok = (width_q == sia_pkg::STOP_QUIET) ||
                    (width_q == sia_pkg::STOP_CONT);

   // -------------------------------------------------------------
   // source capture
   // -------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         src_q <= sia_pkg::LEVELS_RESET;
      end else if (CE) begin
         src_q <= IRQ_LEVELS;
      end
   end

   // -------------------------------------------------------------
   // frame tracking
   // -------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         state_q <= sia_pkg::SIA_S_IDLE;
         ph_q <= sia_pkg::SIA_PH_TURN;
         fr_q <= sia_pkg::START_FRAME;
         width_q <= '0;
      end else if (CE) begin
         if (!SERIRQ_ENABLE) begin
            state_q <= sia_pkg::SIA_S_IDLE;
            width_q <= '0;
         end else begin
            case (state_q)
               sia_pkg::SIA_S_IDLE: begin
                  // a start may come straight after the stop turn-around
                  if (low) begin
                     state_q <= sia_pkg::SIA_S_START;
                     width_q <= sia_pkg::WIDTH_ONE;
                  end
               end
               sia_pkg::SIA_S_START: begin
                  if (low) begin
                     if (width_q != sia_pkg::WIDTH_SAT) begin
                        width_q <= width_q + sia_pkg::WIDTH_ONE;
                     end
                  end else if (width_q >= sia_pkg::START_MIN &&
                               width_q <= sia_pkg::START_MAX) begin
                     // high seen here was the recovery clock, turn-around next
                     state_q <= sia_pkg::SIA_S_FRAMES;
                     ph_q <= sia_pkg::SIA_PH_TURN;
                     fr_q <= sia_pkg::START_FRAME;
                  end else begin
                     // malformed pulse, wait for a clean start
                     state_q <= sia_pkg::SIA_S_IDLE;
                  end
               end
               sia_pkg::SIA_S_FRAMES: begin
                  case (ph_q)
                     sia_pkg::SIA_PH_SAMPLE: begin
                        ph_q <= sia_pkg::SIA_PH_RECOVER;
                     end
                     sia_pkg::SIA_PH_RECOVER: begin
                        ph_q <= sia_pkg::SIA_PH_TURN;
                     end
                     default: begin
                        if (fr_q == sia_pkg::LAST_FRAME) begin
                           state_q <= sia_pkg::SIA_S_STOP_WAIT;
                        end else begin
                           fr_q <= fr_q + sia_pkg::FIRST_FRAME;
                           ph_q <= sia_pkg::SIA_PH_SAMPLE;
                        end
                     end
                  endcase
               end
               sia_pkg::SIA_S_STOP_WAIT: begin
                  // any number of idle clocks, or extra host frames
                  if (low) begin
                     state_q <= sia_pkg::SIA_S_STOP_LOW;
                     width_q <= sia_pkg::WIDTH_ONE;
                  end
               end
               sia_pkg::SIA_S_STOP_LOW: begin
                  if (low) begin
                     if (width_q != sia_pkg::WIDTH_SAT) begin
                        width_q <= width_q + sia_pkg::WIDTH_ONE;
                     end
                  end else if (stop_ok) begin
                     state_q <= sia_pkg::SIA_S_IDLE;
                  end else begin
                     // one-clock lows are other agents' sample phases
                     state_q <= sia_pkg::SIA_S_STOP_WAIT;
                  end
               end
               default: begin
                  state_q <= sia_pkg::SIA_S_IDLE;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // cycle mode
   // -------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         quiet_q <= 1'b0;
      end else if (CE) begin
         if (!SERIRQ_ENABLE) begin
            // back in step only after a stop seen from the start
            quiet_q <= 1'b0;
         end else if (state_q == sia_pkg::SIA_S_STOP_LOW && !low) begin
            if (width_q == sia_pkg::STOP_QUIET) begin
               quiet_q <= 1'b1;
            end else if (width_q == sia_pkg::STOP_CONT) begin
               quiet_q <= 1'b0;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // line drive
   // -------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         oe_q <= 1'b0;
         o_q <= 1'b1;
         drove_q <= 1'b0;
      end else if (CE) begin
         oe_q <= 1'b0;
         o_q <= 1'b1;
         drove_q <= 1'b0;
         if (!SERIRQ_ENABLE) begin
            oe_q <= 1'b0;
         end else if (next_sample) begin
            // frame fr_q+1 carries source bit fr_q
            if (!src_q[fr_q]) begin
               oe_q <= 1'b1;
               o_q <= 1'b0;
               drove_q <= 1'b1;
            end
         end else if (drove_q) begin
            // recovery: push the line back up, then let go
            oe_q <= 1'b1;
         end else if (state_q == sia_pkg::SIA_S_IDLE && quiet_q &&
                      pending && !low && !oe_q) begin
            // idle comes one clock after the stop rising edge
            oe_q <= 1'b1;
            o_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // last reported levels
   // -------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         rep_q <= sia_pkg::LEVELS_RESET;
      end else if (CE) begin
         if (SERIRQ_ENABLE && next_sample) begin
            rep_q[fr_q] <= src_q[fr_q];
         end
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // quiet mode is the only case where this end may start a cycle
   assign QUIET_MODE = quiet_q;
   assign LINK.slave_oe = oe_q;
   assign LINK.slave_o = o_q;

endmodule

/* File: test/serial_irq_slave_agent_tb.sv */
/*
   self-checking bench joining host and slave ends over one link.
   assumes the shared package, the link interface and the checker.
*/
`timescale 1ns/10ps
`define SIA_CHECK(got, exp, what) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("Error at %0t: %s", $time, what); \
      end \
   end

module serial_irq_slave_agent_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic run_en = 1'b1;
   logic poll = 1'b0;
   logic qn = 1'b0;
   logic en = 1'b1;
   logic [3:0] len = 4'h4;
   logic [sia_pkg::NUM_FRAMES-1:0] levels = 17'h1FFFF;
   logic [sia_pkg::NUM_FRAMES-1:0] irq_state;
   logic [sia_pkg::NUM_FRAMES-1:0] lv;
   logic update;
   logic host_quiet;
   logic slave_quiet;
   logic fall_slave = 1'b0;
   logic start_slave = 1'b0;
   int fail_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int run = 0;
   int start_w = 0;
   int last_w = 0;
   int n_start = 0;
   int dis_drv = 0;
   int i;
   int s0;
   integer seed = 32'hef8cc910;

   sia_if link_if ();

   sia_slave sia_slave_i (.CLOCK(clk), .CE(1'b1), .SRST(srst), .SERIRQ_ENABLE(en),
      .IRQ_LEVELS(levels), .QUIET_MODE(slave_quiet), .LINK(link_if));
   sia_host sia_host_i (.CLOCK(clk), .CE(1'b1), .SRST(srst), .RUN(run_en), .POLL(poll),
      .QUIET_NEXT(qn), .START_LEN(len), .IRQ_STATE(irq_state), .UPDATE(update),
      .QUIET_MODE(host_quiet), .LINK(link_if));
   sia_props sia_props_i (.CLOCK(clk), .SRST(srst), .host_o(link_if.host_o),
      .host_oe(link_if.host_oe), .slave_o(link_if.slave_o), .slave_oe(link_if.slave_oe),
      .line(link_if.line));

   always #12.5 clk = ~clk;

   // -------------------------------------------------------------
   // expectations
   // -------------------------------------------------------------
   function automatic int exp_len(input logic [3:0] l);
      if (l < sia_pkg::START_MIN) return int'(sia_pkg::START_MIN);
      if (l > sia_pkg::START_MAX) return int'(sia_pkg::START_MAX);
      return int'(l);
   endfunction

   // -------------------------------------------------------------
   // wire monitor and timeout
   // -------------------------------------------------------------
   always @(negedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         fail_count++;
         $display("Error at %0t: timeout", $time);
         conclude();
      end
      if (!link_if.line) begin
         if (run == 0) fall_slave = link_if.slave_oe & ~link_if.slave_o;
         run++;
         if (run == 4) n_start++;
         if (run == 4) start_slave = fall_slave;
      end else begin
         if (run >= 4) start_w = run;
         if (run != 0) last_w = run;
         run = 0;
      end
      // a disabled slave must leave the pin alone
      if (!en && link_if.slave_oe) dis_drv++;
   end

   // -------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // one whole cycle, host polled or slave started, then its results
   task automatic run_cycle(input logic use_poll, input logic [16:0] exp_state);
      logic got;
      got = 1'b0;
      poll <= use_poll;
      tick(1);
      poll <= 1'b0;
      for (int k = 0; k < 200 && !got; k++) begin
         tick(1);
         if (update === 1'b1) got = 1'b1;
      end
      `SIA_CHECK(got, 1'b1, "no completed cycle")
      `SIA_CHECK(irq_state, exp_state, "collected levels")
      tick(8);
      `SIA_CHECK(start_w, exp_len(len), "start pulse width")
      `SIA_CHECK(last_w, qn ? 2 : 3, "stop pulse width")
      `SIA_CHECK(host_quiet, qn, "host mode after stop")
      `SIA_CHECK(slave_quiet, qn & en, "slave mode after stop")
   endtask

   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      tick(6);
      srst <= 1'b0;
      tick(2);
      `SIA_CHECK(slave_quiet, 1'b0, "slave mode after reset")
      `SIA_CHECK(irq_state, sia_pkg::LEVELS_RESET, "host levels after reset")
      // continuous mode: a level change must not start a cycle
      levels <= 17'h0A5A5;
      tick(30);
      `SIA_CHECK(n_start, 0, "slave started in continuous mode")
      $display("test reset and continuous done");
      // corner start lengths, all-low and all-high levels, then random
      for (i = 0; i < 14; i++) begin
         len <= (i < 4) ? 4'(4 * i + (i == 3 ? 3 : 0)) : 4'($random(seed));
         qn <= (i < 4) ? 1'b0 : 1'($random(seed));
         lv = (i == 4) ? 17'h00000 : (i == 5) ? 17'h1FFFF : 17'($random(seed));
         levels <= lv;
         tick(3);
         run_cycle(1'b1, lv);
      end
      $display("test polled cycles done");
      // quiet mode: slave starts on a change, host completes it
      qn <= 1'b1;
      run_cycle(1'b1, lv);
      qn <= 1'b0;
      levels <= ~lv;
      run_cycle(1'b0, ~lv);
      `SIA_CHECK(start_slave, 1'b1, "first start clock not from slave")
      s0 = n_start;
      levels <= lv;
      tick(70);
      `SIA_CHECK(n_start, s0, "slave started after continuous stop")
      $display("test slave start done");
      // disabled slave: passive and silent, host reads all high
      qn <= 1'b1;
      run_cycle(1'b1, lv);
      en <= 1'b0;
      levels <= ~lv;
      tick(70);
      `SIA_CHECK(n_start, s0 + 1, "disabled slave started a cycle")
      run_cycle(1'b1, 17'h1FFFF);
      `SIA_CHECK(dis_drv, 0, "disabled slave drove the pin")
      en <= 1'b1;
      qn <= 1'b0;
      tick(2);
      run_cycle(1'b1, ~lv);
      $display("test enable done");
      // reset in mid-cycle, then a clean cycle
      poll <= 1'b1;
      tick(1);
      poll <= 1'b0;
      tick(20);
      srst <= 1'b1;
      tick(2);
      srst <= 1'b0;
      tick(1);
      `SIA_CHECK(link_if.slave_oe | link_if.host_oe, 1'b0, "line driven after reset")
      `SIA_CHECK(irq_state, sia_pkg::LEVELS_RESET, "levels after mid reset")
      run_cycle(1'b1, ~lv);
      $display("test mid-cycle reset done");
      conclude();
   end
endmodule

/* File: test/sia_props.sv */
/*
   interface checker for the serialized interrupt link: wire timing of
   both ends seen from the shared line and the four driver signals.
   assumes one clock, synchronous active-high reset, host and slave ends.
*/
`timescale 1ns/10ps
module sia_props (
   // clock and reset
   input wire logic CLOCK,
   input wire logic SRST,
   // link drivers and resolved wire
   input wire logic host_o,
   input wire logic host_oe,
   input wire logic slave_o,
   input wire logic slave_oe,
   input wire logic line
);
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   logic [3:0] lo_q;
   logic [5:0] fr_q;
   logic host_hi;
   logic slv_lo;

   assign host_hi = host_oe & host_o;
   assign slv_lo = slave_oe & ~slave_o;

   // low run length, saturating so a stuck line cannot wrap to legal
   always_ff @(posedge CLOCK) begin
      if (SRST || line) begin
         lo_q <= 4'h0;
      end else if (lo_q != 4'hF) begin
         lo_q <= lo_q + 4'h1;
      end
   end

   // clocks since the start recovery clock
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         fr_q <= 6'h3F;
      end else if (host_hi && lo_q >= 4'h4) begin
         fr_q <= 6'h01;
      end else if (fr_q != 6'h3F) begin
         fr_q <= fr_q + 6'h01;
      end
   end

   default clocking @(posedge CLOCK); endclocking
   default disable iff (SRST);

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   no_clash_a: assert property (!(host_oe && slave_oe && (host_o != slave_o)))
      else $error("host and slave drive opposite levels");
   slave_rec_a: assert property (slave_oe && slave_o |-> $past(slv_lo))
      else $error("slave drove high without a preceding sample low");
   slave_float_a: assert property (slave_oe && slave_o |=> !slave_oe)
      else $error("slave did not float after recovery");
   slave_low_once_a: assert property (slv_lo |=> !slv_lo)
      else $error("slave held the line low for more than one clock");
   slave_low_idle_a: assert property (slv_lo |-> $past(line))
      else $error("slave pulled low while the line was already low");
   pulse_width_a: assert property (host_hi |-> lo_q inside {[4'h2:4'h8]})
      else $error("start or stop pulse of wrong width");
   host_turn_a: assert property (host_hi |=> !host_oe)
      else $error("host did not float after recovery");
   sample_slot_a: assert property (slv_lo && fr_q < 6'd53 |-> fr_q % 3 == 2)
      else $error("slave sample low outside its slot");
   stop_after_a: assert property (host_hi && lo_q < 4'h4 |-> fr_q > 6'd50)
      else $error("stop pulse before all frames");
   stop_gap_a: assert property (host_hi && lo_q < 4'h4 |=> line ##1 1'b1)
      else $error("line low in the clock after stop recovery");

   // -------------------------------------------------------------
   // covers
   // -------------------------------------------------------------
   cover property (host_hi && lo_q == 4'h2);
   cover property (host_hi && lo_q == 4'h3);
   cover property (slv_lo && fr_q > 6'd52);
   cover property (slv_lo && fr_q < 6'd53);
endmodule
